// *** ptt_periodic_tick_timer.sv ***
// periodic tick timer: register slave, clock select and events
module ptt_periodic_tick_timer (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [ptt_pkg::ADDR_W-1:0] avm_address,
    input wire logic avm_read,
    input wire logic avm_write,
    input wire logic [ptt_pkg::DATA_W-1:0] avm_writedata,
    input wire logic [3:0] avm_byteenable,
    output logic [ptt_pkg::DATA_W-1:0] avm_readdata,
    output logic avm_waitrequest,
    input wire logic internal_rc_clock,
    input wire logic crystal_osc_clock,
    input wire logic osc_good_status,
    input wire logic stop_mode,
    output logic tick_irq,
    output logic tick_pulse
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ptt_pkg::REG_W-1:0] ctl;
        logic clk_sel;
        logic pss;
        logic [ptt_pkg::EV_W-1:0] status;
        logic [ptt_pkg::EV_W-1:0] mask;
        logic irq;
        logic tick_pulse;
        logic waitreq;
        logic [ptt_pkg::REG_W-1:0] rdata;
    } ptt_top_type;

    ptt_top_type st_q;
    ptt_top_type st_d;

    logic [ptt_pkg::SYNC_W-1:0] pin_level;
    logic [ptt_pkg::SYNC_W-1:0] pin_rise;
    logic [ptt_pkg::SYNC_W-1:0] pin_fall;
    logic osc_good;
    logic src_edge;
    logic run_ok;
    logic take;
    logic done;
    logic wr;
    logic ctl_wr;
    logic cfg_wr;
    logic mask_wr;
    logic stat_rd;
    logic [ptt_pkg::REG_W-1:0] rd_mux;
    logic [ptt_pkg::EV_W-1:0] ev;
    logic [ptt_pkg::EV_W-1:0] clr;
    logic [ptt_pkg::REG_W-1:0] wdata_lo;

    ptt_tick_if tif ();

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic addr_hit(
        input logic [ptt_pkg::ADDR_W-1:0] addr,
        input logic [ptt_pkg::ADDR_W-1:0] idx
    );
        return addr == {idx[ptt_pkg::ADDR_W-3:0], 2'b00};
    endfunction

    function automatic logic [ptt_pkg::PRE_W-1:0] prescale_limit(
        input logic [ptt_pkg::REG_W-1:0] ctl
    );
        logic [ptt_pkg::RATE_W-1:0] rate;
        rate = ctl[ptt_pkg::RATE_LSB +: ptt_pkg::RATE_W];
        if (ctl[ptt_pkg::DEC_BIT])
            return ptt_pkg::DEC_LIMIT[rate];
        else
            return ptt_pkg::BIN_LIMIT[rate];
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and divide chain
    // ------------------------------------------------------------
    // source clocks are sampled, so each must stay well below
    // a quarter of ref_clk or edges will be lost
    ptt_sync u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in({osc_good_status, crystal_osc_clock,
            internal_rc_clock}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    ptt_divider u_div (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tif(tif)
    );

    assign osc_good = pin_level[ptt_pkg::SRC_GOOD];
    assign wdata_lo = avm_writedata[ptt_pkg::REG_W-1:0];

    // ------------------------------------------------------------
    // tick source and run control
    // ------------------------------------------------------------
    assign src_edge = st_q.clk_sel ? pin_rise[ptt_pkg::SRC_OSC]
        : pin_rise[ptt_pkg::SRC_IRC];
    // stop_mode comes from logic on ref_clk, so it is not synchronised
    assign run_ok = !stop_mode || (st_q.pss && st_q.clk_sel);
    // counter simply stops counting; nothing clears it here
    assign tif.count_en = src_edge && run_ok;
    assign tif.off = !st_q.ctl[ptt_pkg::DEC_BIT]
        && st_q.ctl[ptt_pkg::RATE_LSB +: ptt_pkg::RATE_W]
        == ptt_pkg::RATE_OFF;
    assign tif.pre_limit = prescale_limit(st_q.ctl);
    assign tif.modulus = st_q.ctl[ptt_pkg::MOD_LSB +: ptt_pkg::MOD_W];
    assign tif.restart = ctl_wr || (st_d.clk_sel != st_q.clk_sel);

    // ------------------------------------------------------------
    // bus handshake: one wait cycle, then the access completes
    // ------------------------------------------------------------
    assign take = (avm_read || avm_write) && st_q.waitreq;
    assign done = (avm_read || avm_write) && !st_q.waitreq;
    assign wr = avm_write && done && avm_byteenable[0];
    assign ctl_wr = wr && addr_hit(avm_address, ptt_pkg::CTL_IDX);
    assign cfg_wr = wr && addr_hit(avm_address, ptt_pkg::CFG_IDX);
    assign mask_wr = wr && addr_hit(avm_address, ptt_pkg::MASK_IDX);
    assign stat_rd = avm_read && done
        && addr_hit(avm_address, ptt_pkg::STAT_IDX);

    always_comb
    begin
        rd_mux = '0;
        if (addr_hit(avm_address, ptt_pkg::CTL_IDX))
            rd_mux = st_q.ctl;
        else if (addr_hit(avm_address, ptt_pkg::CFG_IDX))
        begin
            rd_mux[ptt_pkg::SEL_BIT] = st_q.clk_sel;
            rd_mux[ptt_pkg::PSS_BIT] = st_q.pss;
        end
        else if (addr_hit(avm_address, ptt_pkg::STAT_IDX))
            rd_mux = ptt_pkg::REG_W'(st_q.status);
        else if (addr_hit(avm_address, ptt_pkg::MASK_IDX))
            rd_mux = ptt_pkg::REG_W'(st_q.mask);
        else if (addr_hit(avm_address, ptt_pkg::STATE_IDX))
        begin
            rd_mux[ptt_pkg::ST_GOOD_BIT] = osc_good;
            rd_mux[ptt_pkg::ST_STOP_BIT] = stop_mode;
            rd_mux[ptt_pkg::ST_RUN_BIT] = run_ok && !tif.off;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.waitreq = !take;
        if (take)
            st_d.rdata = rd_mux;
        if (ctl_wr)
            st_d.ctl = wdata_lo;
        if (cfg_wr)
        begin
            st_d.clk_sel = wdata_lo[ptt_pkg::SEL_BIT] && osc_good;
            st_d.pss = wdata_lo[ptt_pkg::PSS_BIT];
        end
        // losing the oscillator forces the rc source back
        if (!osc_good)
            st_d.clk_sel = 1'b0;
        if (mask_wr)
            st_d.mask = wdata_lo[ptt_pkg::EV_W-1:0];
        // only bits that the read returned are cleared, so a new
        // event in the same cycle survives
        st_d.status = (st_q.status & ~clr) | ev;
        st_d.irq = |(st_d.status & st_d.mask);
        st_d.tick_pulse = tif.timeout;
    end

    always_comb
    begin
        ev = '0;
        ev[ptt_pkg::EV_TICK] = tif.timeout;
        ev[ptt_pkg::EV_OSC_LOST] = pin_fall[ptt_pkg::SRC_GOOD];
        clr = stat_rd ? st_q.rdata[ptt_pkg::EV_W-1:0] : '0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            st_q <= '0;
            st_q.ctl <= ptt_pkg::CTL_RST;
            st_q.mask <= ptt_pkg::MASK_RST;
            st_q.waitreq <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avm_readdata = {24'h00_0000, st_q.rdata};
    assign avm_waitrequest = st_q.waitreq;
    assign tick_irq = st_q.irq;
    assign tick_pulse = st_q.tick_pulse;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_source_mux: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        tif.count_en |-> (st_q.clk_sel ? pin_rise[ptt_pkg::SRC_OSC]
            : pin_rise[ptt_pkg::SRC_IRC]))
        else $error("tick counted an edge of the wrong source");

    chk_stop_holds: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (stop_mode && !(st_q.pss && st_q.clk_sel) && !tif.restart)
        |=> ($stable(tif.pre_cnt) && $stable(tif.mod_cnt)))
        else $error("tick counter moved during stop");

    chk_count_kept: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (stop_mode && !(st_q.pss && st_q.clk_sel) && !tif.restart
            && !tif.off && tif.pre_cnt != '0)
        |=> tif.pre_cnt != '0)
        else $error("halted tick counter was cleared");

    chk_write_lands: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ctl_wr |=> st_q.ctl == $past(wdata_lo))
        else $error("control write did not land");

    chk_ack_timing: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        take |=> !avm_waitrequest ##1 avm_waitrequest)
        else $error("bus answer not one cycle after request");

    chk_write_restart: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ctl_wr |=> (tif.pre_cnt == '0 && tif.mod_cnt == '0
            && !tif.timeout))
        else $error("control write did not restart the period");

    chk_sel_restart: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $changed(st_q.clk_sel) |-> (tif.pre_cnt == '0
            && tif.mod_cnt == '0))
        else $error("source change did not restart the period");

    chk_dec_table: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        st_q.ctl[ptt_pkg::DEC_BIT] |-> (!tif.off && tif.pre_limit
            == ptt_pkg::DEC_LIMIT[st_q.ctl[6:4]]))
        else $error("decimal table not in effect");

    chk_off_silent: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        tif.off [*2] |-> (!tif.timeout && tif.pre_cnt == '0))
        else $error("tick ran while switched off");

    chk_reset_off: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ($past(rstn) == 1'b0) |-> (st_q.ctl == ptt_pkg::CTL_RST
            && tif.off))
        else $error("control not at off code after reset");

    chk_sel_needs_good: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !osc_good |=> !st_q.clk_sel)
        else $error("crystal select held without good oscillator");

    chk_tick_flag: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        tif.timeout |=> (st_q.status[ptt_pkg::EV_TICK] && tick_pulse))
        else $error("time-out did not raise its event");

    chk_irq_level: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        tick_irq == |(st_q.status & st_q.mask))
        else $error("interrupt level disagrees with status and mask");

    // a read clears only what it returned, and only with no new event
    chk_status_clear: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (stat_rd && !ev[ptt_pkg::EV_TICK]
            && st_q.rdata[ptt_pkg::EV_TICK])
        |=> !st_q.status[ptt_pkg::EV_TICK])
        else $error("status read did not clear the tick event");

    chk_set_wins: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ev[ptt_pkg::EV_TICK] |=> st_q.status[ptt_pkg::EV_TICK])
        else $error("tick event lost against a status read");

    chk_lost_flag: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        pin_fall[ptt_pkg::SRC_GOOD]
        |=> st_q.status[ptt_pkg::EV_OSC_LOST])
        else $error("oscillator loss not flagged");

    chk_pstop_runs: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (stop_mode && st_q.pss && st_q.clk_sel
            && pin_rise[ptt_pkg::SRC_OSC])
        |-> tif.count_en)
        else $error("pseudo stop did not keep the crystal tick");

    chk_sel_accept: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cfg_wr && wdata_lo[ptt_pkg::SEL_BIT] && osc_good)
        |=> st_q.clk_sel)
        else $error("crystal select refused with good oscillator");

    chk_ctl_held: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !ctl_wr |=> $stable(st_q.ctl))
        else $error("control changed without a write");

    chk_bin_table: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (!st_q.ctl[ptt_pkg::DEC_BIT] && !tif.off)
        |-> tif.pre_limit == ptt_pkg::BIN_LIMIT[
            st_q.ctl[ptt_pkg::RATE_LSB +: ptt_pkg::RATE_W]])
        else $error("binary table not in effect");

    chk_pulse_single: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        tick_pulse |=> !tick_pulse)
        else $error("tick pulse longer than one cycle");

    chk_idle_wait: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !(avm_read || avm_write) |=> avm_waitrequest)
        else $error("bus answered without a request");
endmodule

// *** ptt_pkg.sv ***
// shared constants for the periodic tick timer
package ptt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int PRE_W = 18;
    localparam int MOD_W = 4;
    localparam int RATE_W = 3;
    localparam int EV_W = 2;
    localparam int SYNC_W = 3;
    // ------------------------------------------------------------
    // register indices: byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTL_IDX = 8'h0b;
    localparam logic [ADDR_W-1:0] CFG_IDX = 8'h09;
    localparam logic [ADDR_W-1:0] STAT_IDX = 8'h10;
    localparam logic [ADDR_W-1:0] MASK_IDX = 8'h11;
    localparam logic [ADDR_W-1:0] STATE_IDX = 8'h12;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DEC_BIT = 7;
    localparam int RATE_LSB = 4;
    localparam int MOD_LSB = 0;
    localparam int SEL_BIT = 0;
    localparam int PSS_BIT = 1;
    localparam int EV_TICK = 0;
    localparam int EV_OSC_LOST = 1;
    localparam int ST_GOOD_BIT = 0;
    localparam int ST_STOP_BIT = 1;
    localparam int ST_RUN_BIT = 2;
    localparam int SRC_IRC = 0;
    localparam int SRC_OSC = 1;
    localparam int SRC_GOOD = 2;
    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] CTL_RST = 8'h00;
    localparam logic [EV_W-1:0] MASK_RST = 2'h0;
    localparam logic [RATE_W-1:0] RATE_OFF = 3'h0;
    // prescale terminal counts (divide value minus one)
    localparam logic [PRE_W-1:0] BIN_LIMIT [8] = '{
        18'h0_0000, 18'h0_03ff, 18'h0_07ff, 18'h0_0fff,
        18'h0_1fff, 18'h0_3fff, 18'h0_7fff, 18'h0_ffff};
    localparam logic [PRE_W-1:0] DEC_LIMIT [8] = '{
        18'h0_03e7, 18'h0_07cf, 18'h0_1387, 18'h0_270f,
        18'h0_4e1f, 18'h0_c34f, 18'h1_869f, 18'h3_0d3f};
endpackage

// *** ptt_tick_if.sv ***
// carrier between the tick control logic and its divide chain
interface ptt_tick_if;
    logic restart;
    logic count_en;
    logic off;
    logic [ptt_pkg::PRE_W-1:0] pre_limit;
    logic [ptt_pkg::MOD_W-1:0] modulus;
    logic timeout;
    logic [ptt_pkg::PRE_W-1:0] pre_cnt;
    logic [ptt_pkg::MOD_W-1:0] mod_cnt;
    modport ctl (output restart, count_en, off, pre_limit, modulus,
        input timeout, pre_cnt, mod_cnt);
    modport div (input restart, count_en, off, pre_limit, modulus,
        output timeout, pre_cnt, mod_cnt);
endinterface

// *** ptt_sync.sv ***
// three-stage synchroniser with agreement filter and edge pulses
module ptt_sync (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [ptt_pkg::SYNC_W-1:0] async_in,
    output logic [ptt_pkg::SYNC_W-1:0] level,
    output logic [ptt_pkg::SYNC_W-1:0] rise,
    output logic [ptt_pkg::SYNC_W-1:0] fall
);
    typedef struct packed {
        logic [ptt_pkg::SYNC_W-1:0] s1;
        logic [ptt_pkg::SYNC_W-1:0] s2;
        logic [ptt_pkg::SYNC_W-1:0] s3;
        logic [ptt_pkg::SYNC_W-1:0] lvl;
        logic [ptt_pkg::SYNC_W-1:0] rise;
        logic [ptt_pkg::SYNC_W-1:0] fall;
    } ptt_sync_type;
    ptt_sync_type st_q;
    ptt_sync_type st_d;
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // a bit moves only once stages two and three agree
        st_d.lvl = (~(st_q.s2 ^ st_q.s3) & st_q.s2)
            | ((st_q.s2 ^ st_q.s3) & st_q.lvl);
        st_d.rise = st_d.lvl & ~st_q.lvl;
        st_d.fall = ~st_d.lvl & st_q.lvl;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    assign level = st_q.lvl;
    assign rise = st_q.rise;
    assign fall = st_q.fall;
endmodule

// *** ptt_divider.sv ***
// prescale and modulus divide chain for the periodic tick
module ptt_divider (
    input wire logic ref_clk,
    input wire logic rstn,
    ptt_tick_if.div tif
);
    typedef struct packed {
        logic [ptt_pkg::PRE_W-1:0] pre;
        logic [ptt_pkg::MOD_W-1:0] md;
        logic timeout;
    } ptt_div_type;
    ptt_div_type st_q;
    ptt_div_type st_d;
    always_comb
    begin
        st_d = st_q;
        st_d.timeout = 1'b0;
        if (tif.restart || tif.off)
        begin
            st_d.pre = '0;
            st_d.md = '0;
        end
        else if (tif.count_en)
        begin
            // >= so a stale count above a new limit still wraps
            if (st_q.pre >= tif.pre_limit)
            begin
                st_d.pre = '0;
                if (st_q.md >= tif.modulus)
                begin
                    st_d.md = '0;
                    st_d.timeout = 1'b1;
                end
                else
                    st_d.md = st_q.md + 1'b1;
            end
            else
                st_d.pre = st_q.pre + 1'b1;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    assign tif.timeout = st_q.timeout;
    assign tif.pre_cnt = st_q.pre;
    assign tif.mod_cnt = st_q.md;

    chk_period_end: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (tif.count_en && !tif.restart && !tif.off
            && st_q.pre == tif.pre_limit && st_q.md == tif.modulus)
        |=> (st_q.timeout && st_q.pre == '0 && st_q.md == '0))
        else $error("divide chain missed its terminal count");
endmodule

// *** ptt_periodic_tick_timer_tb.sv ***
// self-checking bench for the periodic tick timer
module ptt_periodic_tick_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IRC_HALF = 5;
    localparam int OSC_HALF = 6;
    localparam int IRC_TICK = 1024 * 2 * IRC_HALF;
    localparam int OSC_TICK = 1024 * 2 * OSC_HALF;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [3:0] be;
        logic [7:0] exp;
    } ptt_row_type;
    // ------------------------------------------------------------
    // stimulus signals and design
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [ptt_pkg::ADDR_W-1:0] avm_address = '0;
    logic avm_read = 1'b0;
    logic avm_write = 1'b0;
    logic [ptt_pkg::DATA_W-1:0] avm_writedata = '0;
    logic [3:0] avm_byteenable = 4'h0;
    logic [ptt_pkg::DATA_W-1:0] avm_readdata;
    logic avm_waitrequest;
    logic internal_rc_clock = 1'b0;
    logic crystal_osc_clock = 1'b0;
    logic osc_good_status = 1'b0;
    logic stop_mode = 1'b0;
    logic tick_irq;
    logic tick_pulse;
    int n_errors = 0;
    int tests_run = 0;
    int irc_cnt = 0;
    int osc_cnt = 0;
    int n;
    ptt_row_type rows [8] = '{
        '{8'h2c, 8'ha5, 4'h1, 8'ha5}, '{8'h2c, 8'h5a, 4'h0, 8'ha5},
        '{8'h30, 8'hff, 4'hf, 8'h00}, '{8'h2c, 8'hff, 4'hf, 8'hff},
        '{8'h2c, 8'h00, 4'h1, 8'h00}, '{8'h44, 8'h03, 4'h1, 8'h03},
        '{8'h44, 8'h00, 4'h1, 8'h00}, '{8'h24, 8'h03, 4'h1, 8'h02}};

    ptt_periodic_tick_timer u_ptt_periodic_tick_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .avm_address(avm_address),
        .avm_read(avm_read),
        .avm_write(avm_write),
        .avm_writedata(avm_writedata),
        .avm_byteenable(avm_byteenable),
        .avm_readdata(avm_readdata),
        .avm_waitrequest(avm_waitrequest),
        .internal_rc_clock(internal_rc_clock),
        .crystal_osc_clock(crystal_osc_clock),
        .osc_good_status(osc_good_status),
        .stop_mode(stop_mode),
        .tick_irq(tick_irq),
        .tick_pulse(tick_pulse)
    );

    always #2.5 ref_clk = ~ref_clk;

    // sources run well below ref_clk/4 so no edge is lost in the sync
    always @(posedge ref_clk)
    begin
        irc_cnt <= (irc_cnt == IRC_HALF - 1) ? 0 : irc_cnt + 1;
        osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
        if (irc_cnt == IRC_HALF - 1)
            internal_rc_clock <= ~internal_rc_clock;
        if (osc_cnt == OSC_HALF - 1)
            crystal_osc_clock <= ~crystal_osc_clock;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic check_win(input string what, input int lo,
        input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi)
        begin
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi,
                got);
            n_errors++;
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] addr,
        input logic [7:0] data, input logic [3:0] be,
        output logic [31:0] rd);
        int i;
        @(posedge ref_clk);
        avm_address <= addr;
        avm_write <= wr;
        avm_read <= ~wr;
        avm_writedata <= {24'h00_0000, data};
        avm_byteenable <= be;
        for (i = 0; i < 64; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (avm_waitrequest === 1'b0)
                break;
        end
        if (i == 64)
        begin
            $display("[FAIL] avm_waitrequest expected 0 seen timeout");
            n_errors++;
            tally_and_finish();
        end
        rd = avm_readdata;
        @(posedge ref_clk);
        avm_read <= 1'b0;
        avm_write <= 1'b0;
    endtask

    task automatic wr8(input logic [7:0] addr, input logic [7:0] data);
        logic [31:0] unused;
        bus(1'b1, addr, data, 4'h1, unused);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr,
        input logic [7:0] exp);
        logic [31:0] got;
        bus(1'b0, addr, 8'h00, 4'h1, got);
        check(what, {24'h00_0000, exp}, got);
    endtask

    task automatic idle(input int cycles);
        repeat (cycles) @(posedge ref_clk);
    endtask

    // counts edges until tick_pulse is seen; must means a miss is fatal
    task automatic wait_pulse(input int lim, input bit must, output int k);
        k = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        while (tick_pulse !== 1'b1 && k < lim);
        if (must && tick_pulse !== 1'b1)
        begin
            $display("[FAIL] tick_pulse expected 1 seen timeout");
            n_errors++;
            tally_and_finish();
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        idle(16);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1;
        check("tick_irq reset", 32'h0000_0000, {31'h0, tick_irq});
        check("tick_pulse reset", 32'h0000_0000, {31'h0, tick_pulse});
        rd_chk("control reset", 8'h2c, 8'h00);
        rd_chk("status reset", 8'h40, 8'h00);
        rd_chk("mask reset", 8'h44, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, rows[i].addr, rows[i].data, rows[i].be, n);
            rd_chk("register row", rows[i].addr, rows[i].exp);
        end
        // a second write of the same value must still restart the period
        wr8(8'h2c, 8'h10);
        idle(500);
        wr8(8'h2c, 8'h10);
        wait_pulse(3 * IRC_TICK, 1, n);
        // first source edge after a restart lands 1..10 cycles late
        check_win("restart to tick", IRC_TICK - 8, IRC_TICK + 1, n);
        wait_pulse(3 * IRC_TICK, 1, n);
        check_win("binary period", IRC_TICK, IRC_TICK, n);
        check("tick_irq masked", 32'h0000_0000, {31'h0, tick_irq});
        wr8(8'h44, 8'h01);
        idle(2);
        #1;
        check("tick_irq unmasked", 32'h0000_0001, {31'h0, tick_irq});
        rd_chk("status tick", 8'h40, 8'h01);
        idle(2);
        #1;
        check("tick_irq cleared", 32'h0000_0000, {31'h0, tick_irq});
        wr8(8'h2c, 8'h11);
        wait_pulse(3 * IRC_TICK, 1, n);
        check_win("modulus two", 20472, 20481, n);
        check("tick_irq at tick", 32'h0000_0001, {31'h0, tick_irq});
        rd_chk("status tick", 8'h40, 8'h01);
        // pseudo stop set but rc source: stop must halt and keep the count
        wr8(8'h2c, 8'h10);
        idle(3000);
        stop_mode <= 1'b1;
        idle(2000);
        stop_mode <= 1'b0;
        wait_pulse(3 * IRC_TICK, 1, n);
        // 200 edges are held back, counted from the end of stop
        check_win("stop halts", 7232, 7241, n);
        wr8(8'h2c, 8'h80);
        wait_pulse(3 * IRC_TICK, 1, n);
        check_win("decimal table", 9992, 10001, n);
        osc_good_status <= 1'b1;
        idle(10);
        wr8(8'h24, 8'h03);
        rd_chk("select accepted", 8'h24, 8'h03);
        wr8(8'h2c, 8'h10);
        stop_mode <= 1'b1;
        wait_pulse(3 * OSC_TICK, 1, n);
        check_win("crystal in stop", 12278, 12289, n);
        rd_chk("status tick", 8'h40, 8'h01);
        rd_chk("state in stop", 8'h48, 8'h07);
        stop_mode <= 1'b0;
        idle(600);
        osc_good_status <= 1'b0;
        wait_pulse(3 * OSC_TICK, 1, n);
        // loss is seen five cycles after the pin drops
        check_win("loss restarts", IRC_TICK - 3, IRC_TICK + 6, n);
        rd_chk("select cleared", 8'h24, 8'h02);
        rd_chk("status lost", 8'h40, 8'h03);
        wr8(8'h2c, 8'h00);
        wait_pulse(IRC_TICK + 800, 0, n);
        check("tick off", 32'h0000_0000, {31'h0, tick_pulse});
        wr8(8'h2c, 8'h55);
        rstn <= 1'b0;
        idle(16);
        rstn <= 1'b1;
        rd_chk("control second reset", 8'h2c, 8'h00);
        tally_and_finish();
    end
endmodule
